/* logic/timer_block_consts.vh */
// Purpose: Shared constants for the multimode timer block.
// Assumes: Byte addresses on a six bit register select bus.
// Notes:   Control register offsets sit next to the data registers.
`ifndef TIMER_BLOCK_CONSTS_VH
`define TIMER_BLOCK_CONSTS_VH
`define ADDR_W        6
`define DATA_W        8
`define MODE_W        4
`define SYNC_W        21
`define OFF_EDGE      6'h03
`define OFF_A_CTRL    6'h19
`define OFF_B_CTRL    6'h1b
`define OFF_CD_CTRL   6'h1d
`define OFF_A_RELOAD  6'h1f
`define OFF_B_RELOAD  6'h21
`define OFF_C_RELOAD  6'h23
`define OFF_D_RELOAD  6'h25
`define EDGE_BIT_A    4
`define EDGE_BIT_B    3
`define CTRL_MASK     8'h0f
`define CD_MASK       8'h77
`define CD_C_LSB      4
`define CD_D_LSB      0
`define MODE_STOP     4'h0
`define MODE_EVENT    4'h8
`define MODE_AUX_BIT  3
`define PRE_4         8'h04
`define PRE_10        8'h0a
`define PRE_16        8'h10
`define PRE_50        8'h32
`define PRE_64        8'h40
`define PRE_100       8'h64
`define PRE_200       8'hc8
`define BYTE_ZERO     8'h00
`define BYTE_ONE      8'h01
`define RELOAD_RESET  8'h00
`endif

/* logic/sync2.v */
// Purpose: Two stage synchronizer for a group of pin inputs.
// Assumes: Each bit is an independent level from outside the clock domain.
// Notes:   The first stage feeds only the second stage.
`default_nettype none
`timescale 1ns/10ps
module sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk,    // Block clock.
    input  wire             rstn,   // Asynchronous reset, active low.
    input  wire [WIDTH-1:0] d,      // Raw pin levels.
    input  wire [WIDTH-1:0] init,   // Constant level taken during reset.
    output reg  [WIDTH-1:0] q       // Synchronized levels.
);
    reg [WIDTH-1:0] meta;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= init;
            q    <= init;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // sync2
`default_nettype wire

/* logic/timer_core.v */
// Purpose: One prescaler and 8-bit down counter with reload and timeout.
// Assumes: Mode, strobes and aux levels arrive synchronous to clk.
// Notes:   Mode codes 1 to 7 are delay, 8 is event count, 9 to f pulse width.
`default_nettype none
`timescale 1ns/10ps
`include "timer_block_consts.vh"
module timer_core (
    input  wire               clk,        // Timer clock.
    input  wire               rstn,       // Asynchronous reset, active low.
    input  wire [`MODE_W-1:0] mode,       // Operating mode and prescaler.
    input  wire               aux_active, // Aux input in its active state.
    input  wire               aux_count,  // One pulse per active aux transition.
    input  wire               wr_reload,  // Data register write pulse.
    input  wire [`DATA_W-1:0] wr_data,    // Data register write value.
    output reg  [`DATA_W-1:0] count,      // Main counter.
    output reg                timeout,    // One cycle timeout pulse.
    output reg                timer_out   // Toggles on every timeout.
);
    reg  [`DATA_W-1:0] reload;
    reg  [`DATA_W-1:0] presc;
    reg  [`DATA_W-1:0] div;
    wire stopped    = (mode == `MODE_STOP);
    wire event_mode = (mode == `MODE_EVENT);
    wire pulse_mode = mode[`MODE_AUX_BIT] & ~event_mode;
    wire presc_run  = ~stopped & ~event_mode & (~pulse_mode | aux_active); // R3 R11
    wire presc_done = presc_run & (presc >= div - `BYTE_ONE);
    wire count_pulse = presc_done | (event_mode & aux_count); // R11
    wire through_one = count_pulse & (count == `BYTE_ONE);

    always @* begin
        case (mode[2:0])
            3'h1:    div = `PRE_4;
            3'h2:    div = `PRE_10;
            3'h3:    div = `PRE_16;
            3'h4:    div = `PRE_50;
            3'h5:    div = `PRE_64;
            3'h6:    div = `PRE_100;
            3'h7:    div = `PRE_200;
            default: div = `PRE_4;
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            presc     <= `BYTE_ZERO;
            count     <= `RELOAD_RESET;
            reload    <= `RELOAD_RESET;
            timeout   <= 1'b0;
            timer_out <= 1'b0;
        end else begin
            if (stopped)
                presc <= `BYTE_ZERO; // R22
            else if (presc_run)
                presc <= presc_done ? `BYTE_ZERO : presc + `BYTE_ONE;
            if (wr_reload)
                reload <= wr_data; // R19
            if (wr_reload && stopped)
                count <= wr_data; // R18
            else if (through_one)
                count <= wr_reload ? wr_data : reload; // R7 R12 R20 R9
            else if (count_pulse)
                count <= count - `BYTE_ONE; // R16 R23
            timeout   <= through_one; // R12
            timer_out <= timer_out ^ through_one; // R7 R12
        end
    end
endmodule // timer_core
`default_nettype wire

/* logic/timer_block.v */
// Purpose: Four 8-bit timers, two with pulse width and event count modes.
// Assumes: Host bus pins and aux inputs are asynchronous to clk.
// Notes:   Writes act on the falling data strobe, snapshots on its rise.
//
// Notes on behaviour
// R1 - Timers A and B each have their own auxiliary input for pulse width mode.
// R2 - In aux modes, channels of lines four and three follow aux A and B.
// R3 - Pulse width mode counts only while the aux input is active.
// R4 - Edge bit 4 sets aux A polarity, bit 3 aux B; one is high.
// R5 - Outside pulse width mode, edge bit one means rising, zero falling interrupt.
// R6 - Pulse width mode interrupts on the opposite transition, ending the pulse.
// R7 - Writes during an active pulse count on until through 01, then reload.
// R8 - Software rewrites the data register after reading a measured width.
// R9 - Writes meeting the aux going active may load an undefined counter value.
// R10 - Leaving pulse mode restores edge behaviour; mode or edge changes may interrupt.
// R11 - Event count mode bypasses the prescaler; each active transition decrements.
// R12 - Event count through 01 gives timeout, output toggle and reload.
// R13 - Event input changes at most once every four timer clocks.
// R14 - Event count edge bit one counts rises, zero falls; changes may count.
// R15 - In event mode lines three and four are plain I/O; transitions interrupt.
// R16 - Each main counter is an 8-bit down counter readable at any time.
// R17 - Data register reads return the count caught at the last strobe rise.
// R18 - Writing a stopped timer loads reload value and counter together.
// R19 - Writing a running timer loads only the reload value.
// R20 - Writes meeting the pass through 01 may load an undefined value.
// R21 - Control registers pick mode, prescaler and the stopped state.
// R22 - A stopped timer holds its counter and drops its prescaler residue.
// R23 - Reload 00 gives a timeout after 256 count pulses.
// R24 - Aux inputs pass a two stage synchronizer before any use.
`default_nettype none
`timescale 1ns/10ps
`include "timer_block_consts.vh"
module timer_block (
    input  wire               clk,               // Timer and bus clock, 25 MHz.
    input  wire               rstn,              // Asynchronous reset, active low.
    input  wire               cs_n,              // Chip select, active low.
    input  wire               ds_n,              // Data strobe, active low.
    input  wire               rw,                // One for read, zero for write.
    input  wire [`ADDR_W-1:0] addr,              // Register byte address.
    input  wire [`DATA_W-1:0] data_in,           // Data bus level from the pins.
    output wire [`DATA_W-1:0] data_out,          // Data driven on reads.
    output wire               data_oe,           // High while data_out drives.
    output wire               dtack_n,           // Transfer acknowledge, active low.
    input  wire               timer_a_aux_input, // Timer A auxiliary input.
    input  wire               timer_b_aux_input, // Timer B auxiliary input.
    input  wire               gpio_line_three,   // General purpose line three.
    input  wire               gpio_line_four,    // General purpose line four.
    output wire               channel_four_event, // Interrupt pulse, channel four.
    output wire               channel_three_event, // Interrupt pulse, channel three.
    output wire [3:0]         timer_timeout,     // Timeout pulses, timers A to D.
    output wire [3:0]         timer_output       // Toggling timer outputs A to D.
);
    // Synchronized pin levels.
    wire [`SYNC_W-1:0] sync_q;
    wire               cs_s;
    wire               ds_s;
    wire               rw_s;
    wire [`ADDR_W-1:0] addr_s;
    wire [`DATA_W-1:0] data_s;
    wire [1:0]         aux_s;
    wire [1:0]         gpio_s;

    // Host visible registers.
    reg  [`DATA_W-1:0] edge_polarity_register;
    reg  [`DATA_W-1:0] timer_a_control;
    reg  [`DATA_W-1:0] timer_b_control;
    reg  [`DATA_W-1:0] timer_cd_control;

    // Bus state.
    reg                ds_prev;
    reg  [`DATA_W-1:0] rd_data;
    reg                rd_oe;
    reg                ack_n;
    reg  [3:0]         wr_reload;
    reg  [`DATA_W-1:0] wr_data;
    reg  [`DATA_W-1:0] read_mux;

    // Timer state.
    wire [`MODE_W-1:0] mode [0:3];
    wire [`DATA_W-1:0] count [0:3];
    reg  [`DATA_W-1:0] snap [0:3];
    wire [1:0]         edge_sel;
    wire [1:0]         aux_active;
    wire [1:0]         aux_count;
    wire [1:0]         det;
    reg  [1:0]         det_prev;
    reg  [1:0]         chan_evt;

    wire ds_fall = ds_prev & ~ds_s;
    wire ds_rise = ~ds_prev & ds_s;

    // Every pin passes two flops; strobe and selects idle high.
    sync2 #(
        .WIDTH (`SYNC_W)
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({cs_n, ds_n, rw, addr, data_in, timer_b_aux_input,
                timer_a_aux_input, gpio_line_three, gpio_line_four}), // R24 R13
        .init ({3'h7, 18'h00000}),
        .q    (sync_q)
    );

    assign cs_s   = sync_q[20];
    assign ds_s   = sync_q[19];
    assign rw_s   = sync_q[18];
    assign addr_s = sync_q[17:12];
    assign data_s = sync_q[11:4];
    assign aux_s  = sync_q[3:2];
    assign gpio_s = {sync_q[1], sync_q[0]};

    // Channel 0 is timer A with line four, channel 1 timer B with line three.
    assign edge_sel = {edge_polarity_register[`EDGE_BIT_B],
                       edge_polarity_register[`EDGE_BIT_A]}; // R4

    assign mode[0] = timer_a_control[`MODE_W-1:0]; // R21
    assign mode[1] = timer_b_control[`MODE_W-1:0]; // R21
    assign mode[2] = {1'b0, timer_cd_control[`CD_C_LSB+2:`CD_C_LSB]}; // R21
    assign mode[3] = {1'b0, timer_cd_control[`CD_D_LSB+2:`CD_D_LSB]}; // R21

    // Aux timers: channel source selection and transition detection.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_aux
            wire aux_mode   = mode[g][`MODE_AUX_BIT]; // R1
            wire event_mode = (mode[g] == `MODE_EVENT);
            wire pulse_mode = aux_mode & ~event_mode;
            wire src        = aux_mode ? aux_s[g] : gpio_s[g]; // R2 R15
            wire lvl        = src ~^ edge_sel[g]; // R5 R10 R14
            assign aux_active[g] = aux_s[g] ~^ edge_sel[g]; // R3 R4
            assign det[g]        = pulse_mode ? ~lvl : lvl; // R6 R10
            assign aux_count[g]  = event_mode & det[g] & ~det_prev[g]; // R11 R14

            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    det_prev[g] <= 1'b1;
                    chan_evt[g] <= 1'b0;
                end else begin
                    det_prev[g] <= det[g];
                    chan_evt[g] <= det[g] & ~det_prev[g]; // R5 R6 R15
                end
            end
        end
    endgenerate

    // All four timers with their strobe snapshots.
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_timer
            timer_core u_core (
                .clk        (clk),
                .rstn       (rstn),
                .mode       (mode[g]),
                .aux_active ((g < 2) ? aux_active[g % 2] : 1'b0),
                .aux_count  ((g < 2) ? aux_count[g % 2] : 1'b0),
                .wr_reload  (wr_reload[g]),
                .wr_data    (wr_data),
                .count      (count[g]),
                .timeout    (timer_timeout[g]),
                .timer_out  (timer_output[g])
            );

            always @(posedge clk or negedge rstn) begin
                if (!rstn)
                    snap[g] <= `RELOAD_RESET;
                else if (ds_rise)
                    snap[g] <= count[g]; // R17 R16
            end
        end
    endgenerate

    // Read data selection; unmapped addresses read as zero.
    always @* begin
        case (addr_s)
            `OFF_EDGE:     read_mux = edge_polarity_register;
            `OFF_A_CTRL:   read_mux = timer_a_control;
            `OFF_B_CTRL:   read_mux = timer_b_control;
            `OFF_CD_CTRL:  read_mux = timer_cd_control;
            `OFF_A_RELOAD: read_mux = snap[0]; // R17
            `OFF_B_RELOAD: read_mux = snap[1]; // R17
            `OFF_C_RELOAD: read_mux = snap[2]; // R17
            `OFF_D_RELOAD: read_mux = snap[3]; // R17
            default:       read_mux = `BYTE_ZERO;
        endcase
    end

    // Bus slave: one access per strobe, acknowledge held until strobe release.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            edge_polarity_register <= `BYTE_ZERO;
            timer_a_control        <= `BYTE_ZERO;
            timer_b_control        <= `BYTE_ZERO;
            timer_cd_control       <= `BYTE_ZERO;
            rd_data                <= `BYTE_ZERO;
            rd_oe                  <= 1'b0;
            ack_n                  <= 1'b1;
            ds_prev                <= 1'b1;
            wr_reload              <= 4'h0;
            wr_data                <= `BYTE_ZERO;
        end else begin
            // The strobe history feeds both the access start and the snapshot edge.
            ds_prev   <= ds_s;
            wr_reload <= 4'h0;
            if (ds_fall && !cs_s) begin
                ack_n <= 1'b0;
                if (rw_s) begin
                    rd_oe   <= 1'b1;
                    rd_data <= read_mux;
                end else begin
                    wr_data <= data_s;
                    case (addr_s)
                        `OFF_EDGE:     edge_polarity_register <= data_s;
                        `OFF_A_CTRL:   timer_a_control  <= data_s & `CTRL_MASK; // R21
                        `OFF_B_CTRL:   timer_b_control  <= data_s & `CTRL_MASK; // R21
                        `OFF_CD_CTRL:  timer_cd_control <= data_s & `CD_MASK; // R21
                        `OFF_A_RELOAD: wr_reload <= 4'h1; // R8 R18 R19
                        `OFF_B_RELOAD: wr_reload <= 4'h2; // R18 R19
                        `OFF_C_RELOAD: wr_reload <= 4'h4; // R18 R19
                        `OFF_D_RELOAD: wr_reload <= 4'h8; // R18 R19
                        default:       wr_reload <= 4'h0;
                    endcase
                end
            end else if (ds_s) begin
                ack_n <= 1'b1;
                rd_oe <= 1'b0;
            end
        end
    end

    assign data_out            = rd_data;
    assign data_oe             = rd_oe;
    assign dtack_n             = ack_n;
    assign channel_four_event  = chan_evt[0];
    assign channel_three_event = chan_evt[1];
endmodule // timer_block
`default_nettype wire

/* tb/aux_source.sv */
// Purpose: Model of the outside signal source on the two timer aux inputs.
// Assumes: Levels change just after a rising clock edge.
// Notes:   No level is held for fewer than four clocks.
`timescale 1ns/10ps
`default_nettype none
module aux_source (
    input  wire logic clk,   // Timer clock.
    output var  logic aux_a, // Aux line of timer A.
    output var  logic aux_b  // Aux line of timer B.
);
    initial begin
        aux_a = 1'b0;
        aux_b = 1'b0;
    end
    // Short holds are stretched, so slow and prompt callers both stay legal.
    task automatic drive(input int which, input logic lvl, input int hold);
        @(posedge clk);
        if (which == 0) aux_a <= lvl; else aux_b <= lvl;
        repeat ((hold < 4) ? 4 : hold) @(posedge clk);
    endtask
    task automatic events(input int which, input int n);
        repeat (n) begin
            drive(which, 1'b1, 4);
            drive(which, 1'b0, 4);
        end
    endtask
endmodule // aux_source
`default_nettype wire

/* tb/timer_block_checker.sv */
// Purpose: Port level checks on the multimode timer block.
// Assumes: One clock domain with reset active low.
// Notes:   Attached by bind below.
`timescale 1ns/10ps
`default_nettype none
module timer_block_checker (
    input wire logic       clk,                 // Timer clock.
    input wire logic       rstn,                // Reset, active low.
    input wire logic       cs_n,                // Chip select pin.
    input wire logic       ds_n,                // Data strobe pin.
    input wire logic       rw,                  // Read or write pin.
    input wire logic       data_oe,             // Data bus drive enable.
    input wire logic       dtack_n,             // Acknowledge.
    input wire logic       channel_four_event,  // Channel four pulse.
    input wire logic       channel_three_event, // Channel three pulse.
    input wire logic [3:0] timer_timeout,       // Timeout pulses.
    input wire logic [3:0] timer_output         // Toggle outputs.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_OE_ACK: assert property (data_oe |-> !dtack_n)
        else $error("data bus driven without acknowledge");
    AST_OE_READ: assert property ($rose(data_oe) |-> $past(rw, 2))
        else $error("data bus driven on a write");
    AST_ACK_CS: assert property ($fell(dtack_n) |-> !$past(cs_n, 2))
        else $error("acknowledge without chip select");
    AST_ACK_SOON: assert property ($fell(ds_n) && !cs_n |-> ##[1:4] !dtack_n)
        else $error("access not acknowledged in time");
    AST_ACK_DROP: assert property ($rose(ds_n) |-> ##[1:4] dtack_n)
        else $error("acknowledge not released in time");
    AST_TO_A_ONE: assert property (timer_timeout[0] |=> !timer_timeout[0])
        else $error("timer A timeout longer than one cycle");
    AST_TOGGLE_A: assert property ($changed(timer_output[0]) |-> timer_timeout[0] || $past(timer_timeout[0]))
        else $error("timer A output moved without timeout");
    AST_TOGGLE_B: assert property (timer_timeout[1] |-> ##[0:1] $changed(timer_output[1]))
        else $error("timer B timeout did not toggle output");
    AST_EV4_ONE: assert property (channel_four_event |=> !channel_four_event)
        else $error("channel four pulse too long");
    AST_EV3_ONE: assert property (channel_three_event |=> !channel_three_event)
        else $error("channel three pulse too long");
    CV_READ: cover property ($rose(data_oe));
    CV_TO_C: cover property (timer_timeout[2]);
    CV_EV3: cover property (channel_three_event);
endmodule // timer_block_checker
bind timer_block timer_block_checker chk (.clk(clk), .rstn(rstn), .cs_n(cs_n), .ds_n(ds_n),
    .rw(rw), .data_oe(data_oe), .dtack_n(dtack_n), .channel_four_event(channel_four_event),
    .channel_three_event(channel_three_event), .timer_timeout(timer_timeout),
    .timer_output(timer_output));
`default_nettype wire

/* tb/multimode_timer_pulse_event_bench.sv */
// Purpose: Self-checking bench for the multimode timer block.
// Assumes: Register accesses follow the strobe spacing of the block.
// Notes:   A data register read returns the count caught at the prior strobe.
`timescale 1ns/10ps
`default_nettype none
`include "timer_block_consts.vh"
module multimode_timer_pulse_event_bench;
    logic       clk, rstn, cs_n, ds_n, rw, gpio3, gpio4;
    logic [5:0] addr;
    logic [7:0] data_in, rdat;
    wire  [7:0] data_out;
    wire        data_oe, dtack_n, ev4, ev3, aux_a, aux_b;
    wire  [3:0] tmo, tout;
    int         miscompares = 0;
    int         tests_run = 0;
    int         cyc = 0, n4 = 0, n3 = 0;
    timer_block dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .ds_n(ds_n), .rw(rw), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .dtack_n(dtack_n),
        .timer_a_aux_input(aux_a), .timer_b_aux_input(aux_b), .gpio_line_three(gpio3),
        .gpio_line_four(gpio4), .channel_four_event(ev4), .channel_three_event(ev3),
        .timer_timeout(tmo), .timer_output(tout));
    aux_source src (.clk(clk), .aux_a(aux_a), .aux_b(aux_b));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk) begin
        cyc++;
        n4 += int'(ev4 === 1'b1);
        n3 += int'(ev3 === 1'b1);
        if (cyc == 12000) begin
            miscompares++;
            $display("ERROR %0t run did not finish", $time);
            end_of_test();
        end
    end
    task automatic end_of_test;
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmpn(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            miscompares++;
            $display("ERROR %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    // Address and data settle three clocks before the strobe and stay until release.
    task automatic acc(input logic r, input logic [5:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        cs_n    <= 1'b0;
        rw      <= r;
        addr    <= a;
        data_in <= d;
        repeat (3) @(posedge clk);
        ds_n <= 1'b0;
        for (k = 0; k < 30 && dtack_n !== 1'b0; k++) @(posedge clk);
        rdat = data_out;
        ds_n <= 1'b1;
        for (k = 0; k < 30 && dtack_n !== 1'b1; k++) @(posedge clk);
        cs_n <= 1'b1;
        rw   <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        acc(1'b0, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        acc(1'b1, a, 8'h00);
        acc(1'b1, a, 8'h00);
        cmp(rdat, exp);
    endtask
    task automatic t_stopped;
        wr(`OFF_A_RELOAD, 8'h05);
        rd(`OFF_A_RELOAD, 8'h05);
        rd(6'h3f, 8'h00);
        n4 = 0;
        gpio4 <= 1'b1;
        repeat (8) @(posedge clk);
        gpio4 <= 1'b0;
        repeat (8) @(posedge clk);
        cmpn(n4, 1);
    endtask
    task automatic t_event_a;
        wr(`OFF_A_RELOAD, 8'h03);
        wr(`OFF_EDGE, 8'h10);
        wr(`OFF_A_CTRL, `MODE_EVENT);
        n4 = 0;
        src.events(0, 2);
        rd(`OFF_A_RELOAD, 8'h01);
        wr(`OFF_A_RELOAD, 8'h04);
        rd(`OFF_A_RELOAD, 8'h01);
        src.events(0, 1);
        rd(`OFF_A_RELOAD, 8'h04);
        cmp({7'h00, tout[0]}, 8'h01);
        cmpn(n4, 3);
    endtask
    task automatic t_event_b;
        wr(`OFF_B_RELOAD, 8'h02);
        wr(`OFF_B_CTRL, `MODE_EVENT);
        n3 = 0;
        src.events(1, 2);
        rd(`OFF_B_RELOAD, 8'h02);
        cmp({7'h00, tout[1]}, 8'h01);
        cmpn(n3, 2);
    endtask
    task automatic t_pulse;
        wr(`OFF_A_CTRL, `MODE_STOP);
        wr(`OFF_A_RELOAD, 8'h10);
        wr(`OFF_A_CTRL, 8'h09);
        n4 = 0;
        src.drive(0, 1'b1, 40);
        cmpn(n4, 0);
        src.drive(0, 1'b0, 8);
        cmpn(n4, 1);
        rd(`OFF_A_RELOAD, 8'h06);
        repeat (40) @(posedge clk);
        rd(`OFF_A_RELOAD, 8'h06);
        wr(`OFF_A_RELOAD, 8'h10);
        wr(`OFF_A_CTRL, `MODE_STOP);
    endtask
    task automatic t_delay_zero;
        int k;
        wr(`OFF_C_RELOAD, 8'h00);
        wr(`OFF_D_RELOAD, 8'h00);
        wr(`OFF_CD_CTRL, 8'h11);
        for (k = 0; k < 1100 && tmo[2] !== 1'b1; k++) @(negedge clk);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (tmo[2] !== 1'b1 && k < 1100);
        cmpn(k, 1024);
        cmp({6'h00, tmo[3:2]}, 8'h03);
        cmp({6'h00, tout[3:2]}, 8'h00);
        wr(`OFF_CD_CTRL, 8'h00);
    endtask
    initial begin
        rstn    <= 1'b0;
        cs_n    <= 1'b1;
        ds_n    <= 1'b1;
        rw      <= 1'b1;
        addr    <= 6'h00;
        data_in <= 8'h00;
        gpio3   <= 1'b0;
        gpio4   <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_stopped();
        t_event_a();
        t_event_b();
        t_pulse();
        t_delay_zero();
        end_of_test();
    end
endmodule // multimode_timer_pulse_event_bench
`default_nettype wire
